// File: pkg/rfx_defs.vh
/*
  Constants of the CPU register file and flag block: register
  indices on the software port, flag bit positions, operand sizes
  and the fixed vector table addresses.
  Assumes it is included by bare name into the design and the bench.
*/
`ifndef RFX_DEFS_VH
`define RFX_DEFS_VH

// Register indices on the software port
`define RFX_IDX_DATA0      5'h00
`define RFX_IDX_DATA1      5'h01
`define RFX_IDX_DATA2      5'h02
`define RFX_IDX_DATA3      5'h03
`define RFX_IDX_ADDR0      5'h04
`define RFX_IDX_ADDR1      5'h05
`define RFX_IDX_FB         5'h06
`define RFX_IDX_VECTOR_TABLE_BASE       5'h07
`define RFX_IDX_PC         5'h08
`define RFX_IDX_USP        5'h09
`define RFX_IDX_ISP        5'h0A
`define RFX_IDX_SB         5'h0B
`define RFX_IDX_FLG        5'h0C
`define RFX_IDX_D0_HI      5'h0D
`define RFX_IDX_D0_LO      5'h0E
`define RFX_IDX_D1_HI      5'h0F
`define RFX_IDX_D1_LO      5'h10
`define RFX_IDX_PAIR_LO    5'h11
`define RFX_IDX_PAIR_HI    5'h12
`define RFX_IDX_ADDR_PAIR  5'h13
`define RFX_IDX_ACT_SP     5'h14

// Banked set layout
`define RFX_BANK_SLOTS     7
`define RFX_BANK_ENTRIES   14

// Internal flag bit positions (11 bits held)
`define RFX_F_C            0
`define RFX_F_D            1
`define RFX_F_Z            2
`define RFX_F_S            3
`define RFX_F_B            4
`define RFX_F_O            5
`define RFX_F_I            6
`define RFX_F_U            7
`define RFX_F_IPL_LSB      8
`define RFX_FLG_RESET      11'h000
// Visible position of the priority level field
`define RFX_V_IPL_LSB      12

// ALU flag mask bits
`define RFX_M_C            0
`define RFX_M_Z            1
`define RFX_M_S            2
`define RFX_M_O            3

// Operand sizes
`define RFX_SZ_BYTE        2'h0
`define RFX_SZ_WORD        2'h1
`define RFX_SZ_LONG        2'h2

// Fixed vector table and software interrupt boundary
`define RFX_FIXVEC_FIRST   20'h0FFDC
`define RFX_FIXVEC_LAST    20'h0FFFF
`define RFX_FIXVEC_RESET   20'h0FFFC
`define RFX_SWI_USTK_MAX   6'h1F

`endif

// File: logic/rfx_core_regs.v
/*
  CPU register file and flag register: two banks of data, address
  and frame base registers, static base, vector table base, program
  counter, two stack pointers and the 11-bit flag word, with flag
  update from the ALU and interrupt acknowledge.
  Assumes all inputs come from logic on clk_i; the software port
  never raises both strobes in one cycle.
*/
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "rfx_defs.vh"

// Notes on behaviour
// - Zero flag is 1 for a zero arithmetic result, else 0.
// - Sign flag is 1 for a negative result, else 0.
// - Overflow flag is 1 when the operation overflows, else 0.
// - Carry flag takes the ALU carry, borrow or shifted-out bit.
// - Bank flag 0 routes accesses to bank 0, 1 to bank 1.
// - Maskable interrupts are taken only while the enable flag is 1.
// - Any interrupt acknowledge clears the interrupt enable flag.
// - Stack flag 0 selects interrupt stack pointer, 1 the user one.
// - Hardware acknowledge or software interrupt 0 to 31 clears stack flag.
// - Priority level is a 3-bit field, levels 0 to 7.
// - A request is enabled only above the current priority level.
// - First two data registers split into 8-bit high and low halves.
// - Data registers 0/2 and 1/3 form 32-bit pairs.
// - Address registers combine into 32 bits, second one upper.
// - Two full copies of data, address and frame base registers.
// - A 20-bit program counter holds the next instruction address.
// - A 20-bit vector table base holds the relocatable table start.
// - Both stack pointers, frame base and static base are 16 bits.
// - The flag register holds 11 bits of processor state.
// - Reserved flag bits read undefined; here they read as 0.
// - Fixed routine addresses come from the top of the low 64 KB.
module rfx_core_regs #(
  parameter [19:0] RESET_VEC = `RFX_FIXVEC_RESET // Reset entry address
) (
  input  wire        clk_i,        // System clock
  input  wire        srst_i,       // Synchronous reset, active high
  input  wire [4:0]  reg_addr_i,   // Register index
  input  wire [31:0] reg_wdata_i,  // Write data
  input  wire        reg_we_i,     // Write strobe
  input  wire        reg_re_i,     // Read strobe
  output wire [31:0] reg_rdata_o,  // Read data, cycle after strobe
  input  wire        alu_we_i,     // ALU flag update strobe
  input  wire [3:0]  alu_mask_i,   // Flags the instruction affects
  input  wire [1:0]  alu_size_i,   // Operand size
  input  wire [31:0] alu_res_i,    // ALU result
  input  wire        alu_c_i,      // Carry, borrow or shift-out
  input  wire        alu_o_i,      // Overflow
  input  wire        irq_req_i,    // Maskable request pending
  input  wire [2:0]  irq_lvl_i,    // Priority of the request
  output wire        irq_take_o,   // Request may be acknowledged
  input  wire        hw_ack_i,     // Hardware interrupt acknowledged
  input  wire        swi_exec_i,   // Software interrupt executed
  input  wire [5:0]  swi_num_i,    // Software interrupt number
  output wire        vec_req_o,    // Reset vector fetch pending
  output wire [19:0] vec_addr_o,   // Vector fetch address
  input  wire        vec_vld_i,    // Vector data valid
  input  wire [19:0] vec_data_i,   // Fetched routine address
  output wire [19:0] pc_o,         // Program counter
  output wire [19:0] vector_table_base_o,       // Vector table base
  output wire [15:0] sp_o,         // Active stack pointer
  output wire [15:0] flags_o       // Flag word, visible layout
);

  // Non-banked state
  reg [19:0] pc_ff;
  reg [19:0] nxt_pc;
  reg [19:0] vector_table_base_ff;
  reg [19:0] nxt_vector_table_base;
  reg [15:0] usp_ff;
  reg [15:0] nxt_usp;
  reg [15:0] isp_ff;
  reg [15:0] nxt_isp;
  reg [15:0] sb_ff;
  reg [15:0] nxt_sb;
  reg [10:0] flg_ff;
  reg [10:0] nxt_flg;
  reg        boot_ff;
  reg        nxt_boot;
  reg [31:0] rdata_ff;
  reg [31:0] nxt_rdata;
  reg [15:0] sp_ff;
  reg [15:0] nxt_sp;

  wire [15:0] ent_w [0:`RFX_BANK_ENTRIES-1];
  wire        bsel;
  wire        use_usp;
  wire [2:0]  processor_priority_level;
  wire [15:0] flg_vis;

  assign bsel    = flg_ff[`RFX_F_B];
  assign use_usp = flg_ff[`RFX_F_U];
  assign processor_priority_level     = flg_ff[`RFX_F_IPL_LSB +: 3];

  // Visible word; reserved bits read as zero so software that
  // compares a read-back word never sees stray ones
  assign flg_vis = {1'b0, processor_priority_level, 4'h0, flg_ff[7:0]};

  // Banked set: two copies of seven 16-bit entries
  genvar g;
  generate
    for (g = 0; g < `RFX_BANK_ENTRIES; g = g + 1) begin : g_ent
      // Integer bank and slot numbers, cut to the widths compared at
      localparam integer BKI = g / `RFX_BANK_SLOTS;
      localparam integer SLI = g % `RFX_BANK_SLOTS;
      localparam [0:0]   BK  = BKI[0:0];
      localparam [4:0]   SL  = SLI[4:0];
      reg  [15:0] ent_ff;
      reg  [15:0] nxt_ent;
      wire        wr;

      // Only the bank named by the flag sees writes
      assign wr = reg_we_i & (bsel == BK);

      // Full, byte and pair views onto this entry
      always @* begin
        nxt_ent = ent_ff;
        if (wr) begin
          if (reg_addr_i == SL) begin
            nxt_ent = reg_wdata_i[15:0];
          end else if (SL == 5'h00 && reg_addr_i == `RFX_IDX_D0_HI) begin
            nxt_ent[15:8] = reg_wdata_i[7:0];
          end else if (SL == 5'h00 && reg_addr_i == `RFX_IDX_D0_LO) begin
            nxt_ent[7:0] = reg_wdata_i[7:0];
          end else if (SL == 5'h01 && reg_addr_i == `RFX_IDX_D1_HI) begin
            nxt_ent[15:8] = reg_wdata_i[7:0];
          end else if (SL == 5'h01 && reg_addr_i == `RFX_IDX_D1_LO) begin
            nxt_ent[7:0] = reg_wdata_i[7:0];
          end else if (reg_addr_i == `RFX_IDX_PAIR_LO) begin
            if (SL == 5'h00) begin
              nxt_ent = reg_wdata_i[15:0];
            end else if (SL == 5'h02) begin
              nxt_ent = reg_wdata_i[31:16];
            end
          end else if (reg_addr_i == `RFX_IDX_PAIR_HI) begin
            if (SL == 5'h01) begin
              nxt_ent = reg_wdata_i[15:0];
            end else if (SL == 5'h03) begin
              nxt_ent = reg_wdata_i[31:16];
            end
          end else if (reg_addr_i == `RFX_IDX_ADDR_PAIR) begin
            if (SL == 5'h04) begin
              nxt_ent = reg_wdata_i[15:0];
            end else if (SL == 5'h05) begin
              nxt_ent = reg_wdata_i[31:16];
            end
          end
        end
      end

      // Entry storage
      always @(posedge clk_i) begin
        if (srst_i) begin
          ent_ff <= 16'h0000;
        end else begin
          ent_ff <= nxt_ent;
        end
      end

      assign ent_w[g] = ent_ff;
    end
  endgenerate

  // Current bank view of each slot
  wire [15:0] cur_d0;
  wire [15:0] cur_d1;
  wire [15:0] cur_d2;
  wire [15:0] cur_d3;
  wire [15:0] cur_a0;
  wire [15:0] cur_a1;
  wire [15:0] cur_fb;

  assign cur_d0 = bsel ? ent_w[7]  : ent_w[0];
  assign cur_d1 = bsel ? ent_w[8]  : ent_w[1];
  assign cur_d2 = bsel ? ent_w[9]  : ent_w[2];
  assign cur_d3 = bsel ? ent_w[10] : ent_w[3];
  assign cur_a0 = bsel ? ent_w[11] : ent_w[4];
  assign cur_a1 = bsel ? ent_w[12] : ent_w[5];
  assign cur_fb = bsel ? ent_w[13] : ent_w[6];

  // Zero and sign taken at the operand size
  reg res_zero;
  reg res_neg;

  always @* begin
    res_zero = 1'b0;
    res_neg  = 1'b0;
    if (alu_size_i == `RFX_SZ_BYTE) begin
      res_zero = (alu_res_i[7:0] == 8'h00);
      res_neg  = alu_res_i[7];
    end else if (alu_size_i == `RFX_SZ_WORD) begin
      res_zero = (alu_res_i[15:0] == 16'h0000);
      res_neg  = alu_res_i[15];
    end else begin
      res_zero = (alu_res_i == 32'h00000000);
      res_neg  = alu_res_i[31];
    end
  end

  // Flag update; acknowledge comes last so its clears always win
  always @* begin
    nxt_flg = flg_ff;
    if (alu_we_i) begin
      // Untouched mask bits keep their flags
      if (alu_mask_i[`RFX_M_C]) begin
        nxt_flg[`RFX_F_C] = alu_c_i;
      end
      if (alu_mask_i[`RFX_M_Z]) begin
        nxt_flg[`RFX_F_Z] = res_zero;
      end
      if (alu_mask_i[`RFX_M_S]) begin
        nxt_flg[`RFX_F_S] = res_neg;
      end
      if (alu_mask_i[`RFX_M_O]) begin
        nxt_flg[`RFX_F_O] = alu_o_i;
      end
    end
    // Software write overrides a same-cycle ALU update
    if (reg_we_i && reg_addr_i == `RFX_IDX_FLG) begin
      nxt_flg = {reg_wdata_i[`RFX_V_IPL_LSB +: 3], reg_wdata_i[7:0]};
    end
    if (hw_ack_i) begin
      nxt_flg[`RFX_F_I] = 1'b0;
      nxt_flg[`RFX_F_U] = 1'b0;
    end
    if (swi_exec_i) begin
      nxt_flg[`RFX_F_I] = 1'b0;
      if (swi_num_i <= `RFX_SWI_USTK_MAX) begin
        nxt_flg[`RFX_F_U] = 1'b0;
      end
    end
  end

  // Non-banked register writes and reset vector load
  always @* begin
    nxt_pc   = pc_ff;
    nxt_vector_table_base = vector_table_base_ff;
    nxt_usp  = usp_ff;
    nxt_isp  = isp_ff;
    nxt_sb   = sb_ff;
    nxt_boot = boot_ff;
    if (boot_ff) begin
      // Port writes to the PC are held off until the vector lands
      if (vec_vld_i) begin
        nxt_pc   = vec_data_i;
        nxt_boot = 1'b0;
      end
    end else if (reg_we_i && reg_addr_i == `RFX_IDX_PC) begin
      nxt_pc = reg_wdata_i[19:0];
    end
    if (reg_we_i) begin
      if (reg_addr_i == `RFX_IDX_VECTOR_TABLE_BASE) begin
        nxt_vector_table_base = reg_wdata_i[19:0];
      end else if (reg_addr_i == `RFX_IDX_USP) begin
        nxt_usp = reg_wdata_i[15:0];
      end else if (reg_addr_i == `RFX_IDX_ISP) begin
        nxt_isp = reg_wdata_i[15:0];
      end else if (reg_addr_i == `RFX_IDX_SB) begin
        nxt_sb = reg_wdata_i[15:0];
      end else if (reg_addr_i == `RFX_IDX_ACT_SP) begin
        if (use_usp) begin
          nxt_usp = reg_wdata_i[15:0];
        end else begin
          nxt_isp = reg_wdata_i[15:0];
        end
      end
    end
  end

  // Active pointer taken from next-state values, so it follows a
  // stack flag or pointer change on the same edge
  always @* begin
    nxt_sp = nxt_flg[`RFX_F_U] ? nxt_usp : nxt_isp;
  end

  // Read mux; unmapped indices read zero
  always @* begin
    nxt_rdata = 32'h00000000;
    if (reg_re_i) begin
      if (reg_addr_i == `RFX_IDX_DATA0) begin
        nxt_rdata = {16'h0000, cur_d0};
      end else if (reg_addr_i == `RFX_IDX_DATA1) begin
        nxt_rdata = {16'h0000, cur_d1};
      end else if (reg_addr_i == `RFX_IDX_DATA2) begin
        nxt_rdata = {16'h0000, cur_d2};
      end else if (reg_addr_i == `RFX_IDX_DATA3) begin
        nxt_rdata = {16'h0000, cur_d3};
      end else if (reg_addr_i == `RFX_IDX_ADDR0) begin
        nxt_rdata = {16'h0000, cur_a0};
      end else if (reg_addr_i == `RFX_IDX_ADDR1) begin
        nxt_rdata = {16'h0000, cur_a1};
      end else if (reg_addr_i == `RFX_IDX_FB) begin
        nxt_rdata = {16'h0000, cur_fb};
      end else if (reg_addr_i == `RFX_IDX_VECTOR_TABLE_BASE) begin
        nxt_rdata = {12'h000, vector_table_base_ff};
      end else if (reg_addr_i == `RFX_IDX_PC) begin
        nxt_rdata = {12'h000, pc_ff};
      end else if (reg_addr_i == `RFX_IDX_USP) begin
        nxt_rdata = {16'h0000, usp_ff};
      end else if (reg_addr_i == `RFX_IDX_ISP) begin
        nxt_rdata = {16'h0000, isp_ff};
      end else if (reg_addr_i == `RFX_IDX_SB) begin
        nxt_rdata = {16'h0000, sb_ff};
      end else if (reg_addr_i == `RFX_IDX_FLG) begin
        nxt_rdata = {16'h0000, flg_vis};
      end else if (reg_addr_i == `RFX_IDX_D0_HI) begin
        nxt_rdata = {24'h000000, cur_d0[15:8]};
      end else if (reg_addr_i == `RFX_IDX_D0_LO) begin
        nxt_rdata = {24'h000000, cur_d0[7:0]};
      end else if (reg_addr_i == `RFX_IDX_D1_HI) begin
        nxt_rdata = {24'h000000, cur_d1[15:8]};
      end else if (reg_addr_i == `RFX_IDX_D1_LO) begin
        nxt_rdata = {24'h000000, cur_d1[7:0]};
      end else if (reg_addr_i == `RFX_IDX_PAIR_LO) begin
        nxt_rdata = {cur_d2, cur_d0};
      end else if (reg_addr_i == `RFX_IDX_PAIR_HI) begin
        nxt_rdata = {cur_d3, cur_d1};
      end else if (reg_addr_i == `RFX_IDX_ADDR_PAIR) begin
        nxt_rdata = {cur_a1, cur_a0};
      end else if (reg_addr_i == `RFX_IDX_ACT_SP) begin
        nxt_rdata = {16'h0000, sp_o};
      end
    end
  end

  // State registers; the boot flag holds off PC writes until the
  // reset vector has been fetched
  always @(posedge clk_i) begin
    if (srst_i) begin
      pc_ff    <= 20'h00000;
      vector_table_base_ff  <= 20'h00000;
      usp_ff   <= 16'h0000;
      isp_ff   <= 16'h0000;
      sb_ff    <= 16'h0000;
      flg_ff   <= `RFX_FLG_RESET;
      boot_ff  <= 1'b1;
      rdata_ff <= 32'h00000000;
      sp_ff    <= 16'h0000;
    end else begin
      pc_ff    <= nxt_pc;
      vector_table_base_ff  <= nxt_vector_table_base;
      usp_ff   <= nxt_usp;
      isp_ff   <= nxt_isp;
      sb_ff    <= nxt_sb;
      flg_ff   <= nxt_flg;
      boot_ff  <= nxt_boot;
      rdata_ff <= nxt_rdata;
      sp_ff    <= nxt_sp;
    end
  end

  // Interrupt gate: enable flag and strictly higher priority
  // Left combinational so the core can acknowledge in the same cycle;
  // a request at the current level is held off
  assign irq_take_o = irq_req_i & flg_ff[`RFX_F_I] & (irq_lvl_i > processor_priority_level);

  // Reset entry sits in the fixed table at the top of the low 64 KB
  assign vec_req_o  = boot_ff;
  assign vec_addr_o = RESET_VEC;

  // Outputs to the core
  assign sp_o        = sp_ff;
  assign pc_o        = pc_ff;
  assign vector_table_base_o      = vector_table_base_ff;
  assign flags_o     = flg_vis;
  assign reg_rdata_o = rdata_ff;

endmodule // rfx_core_regs

// File: bench/rfx_core_regs_assertions.sv
/* Checker for the register file and flag block, bound to its top.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module rfx_core_regs_chk #(
  parameter [19:0] RESET_VEC = 20'h0FFFC // Reset entry
) (
  input wire        clk_i,       // Clock
  input wire        srst_i,      // Reset
  input wire [4:0]  reg_addr_i,  // Index
  input wire        reg_we_i,    // Write
  input wire        reg_re_i,    // Read
  input wire [31:0] reg_rdata_o, // Read data
  input wire        alu_we_i,    // ALU strobe
  input wire [3:0]  alu_mask_i,  // ALU mask
  input wire [1:0]  alu_size_i,  // Size
  input wire [31:0] alu_res_i,   // Result
  input wire        alu_c_i,     // Carry
  input wire        alu_o_i,     // Overflow
  input wire        irq_req_i,   // Request
  input wire [2:0]  irq_lvl_i,   // Level
  input wire        irq_take_o,  // Take
  input wire        hw_ack_i,    // Hw ack
  input wire        swi_exec_i,  // Sw int
  input wire [5:0]  swi_num_i,   // Sw number
  input wire        vec_req_o,   // Fetch pending
  input wire [19:0] vec_addr_o,  // Fetch address
  input wire        vec_vld_i,   // Vector valid
  input wire [19:0] vec_data_i,  // Vector data
  input wire [19:0] pc_o,        // PC
  input wire [15:0] flags_o      // Flags
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // Zero and sign of the result at the operand size
  wire zro = (alu_size_i == 2'h0) ? (alu_res_i[7:0] == 8'h00) :
             (alu_size_i == 2'h1) ? (alu_res_i[15:0] == 16'h0000) : (alu_res_i == 32'h0);
  wire sgn = (alu_size_i == 2'h0) ? alu_res_i[7] :
             (alu_size_i == 2'h1) ? alu_res_i[15] : alu_res_i[31];
  // A same-cycle flag write overrides the ALU
  wire upd = alu_we_i && !(reg_we_i && reg_addr_i == 5'h0C);
  a_irq_gate: assert property (irq_take_o ==
    (irq_req_i && flags_o[6] && irq_lvl_i > flags_o[14:12]))
    else $error("interrupt take disagrees with enable and level");
  a_ack_clr_i: assert property (hw_ack_i || swi_exec_i |=> !flags_o[6])
    else $error("enable flag not cleared on acknowledge");
  a_ack_clr_u: assert property (hw_ack_i || (swi_exec_i && swi_num_i <= 6'h1F)
    |=> !flags_o[7])
    else $error("stack flag not cleared");
  a_zero_flag: assert property (upd && alu_mask_i[1] |=> flags_o[2] == $past(zro))
    else $error("zero flag wrong");
  a_sign_flag: assert property (upd && alu_mask_i[2] |=> flags_o[3] == $past(sgn))
    else $error("sign flag wrong");
  a_carry_flag: assert property (upd && alu_mask_i[0] |=> flags_o[0] == $past(alu_c_i))
    else $error("carry flag wrong");
  a_ovf_flag: assert property (upd && alu_mask_i[3] |=> flags_o[5] == $past(alu_o_i))
    else $error("overflow flag wrong");
  a_flags_hold: assert property (!alu_we_i && !reg_we_i && !hw_ack_i && !swi_exec_i
    |=> $stable(flags_o))
    else $error("flags changed without cause");
  a_vec_load: assert property (vec_req_o && vec_vld_i
    |=> !vec_req_o && pc_o == $past(vec_data_i))
    else $error("reset vector not loaded");
  a_vec_addr: assert property (vec_addr_o == RESET_VEC)
    else $error("vector address wrong");
  a_rd_idle: assert property (!reg_re_i |=> reg_rdata_o == 32'h0)
    else $error("read data outside read slot");
endmodule // rfx_core_regs_chk

bind rfx_core_regs rfx_core_regs_chk #(.RESET_VEC(RESET_VEC)) u_chk (.*);

// File: bench/testbench.sv
/* Self-checking bench for the register file and flag block.
   Assumes rfx_defs.vh is on the include path. */
`timescale 1ns/1ps
`include "rfx_defs.vh"
module testbench;
  logic        clk_i = 0, srst_i = 1, reg_we_i = 0, reg_re_i = 0, alu_we_i = 0;
  logic        alu_c_i = 0, alu_o_i = 0, irq_req_i = 0, hw_ack_i = 0, swi_exec_i = 0;
  logic        vec_vld_i = 0, irq_take_o, vec_req_o, rd_flag = 0;
  logic [4:0]  reg_addr_i = 0;
  logic [31:0] reg_wdata_i = 0, alu_res_i = 0, reg_rdata_o, r;
  logic [3:0]  alu_mask_i = 0, m;
  logic [1:0]  alu_size_i = 0, sz;
  logic [2:0]  irq_lvl_i = 0;
  logic [5:0]  swi_num_i = 0;
  logic [19:0] vec_data_i = 0, vec_addr_o, pc_o, vector_table_base_o;
  logic [15:0] sp_o, flags_o, ef, bv [0:1][0:6];
  logic [31:0] q [$];
  int          err_total = 0, cmp_count = 0, cyc = 0, seed = 42498, i, b;

  rfx_core_regs uut (.clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .alu_we_i(alu_we_i), .alu_mask_i(alu_mask_i),
    .alu_size_i(alu_size_i), .alu_res_i(alu_res_i), .alu_c_i(alu_c_i), .alu_o_i(alu_o_i),
    .irq_req_i(irq_req_i), .irq_lvl_i(irq_lvl_i), .irq_take_o(irq_take_o),
    .hw_ack_i(hw_ack_i), .swi_exec_i(swi_exec_i), .swi_num_i(swi_num_i),
    .vec_req_o(vec_req_o), .vec_addr_o(vec_addr_o), .vec_vld_i(vec_vld_i),
    .vec_data_i(vec_data_i), .pc_o(pc_o), .vector_table_base_o(vector_table_base_o), .sp_o(sp_o), .flags_o(flags_o));

  always #5 clk_i = ~clk_i;

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Every strobe set once per edge, so back-to-back calls never double-assign
  task automatic drv(input logic [5:0] s, input logic [4:0] a, input logic [31:0] d);
    {reg_we_i, reg_re_i, alu_we_i, hw_ack_i, swi_exec_i, vec_vld_i} <= s;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    drv(6'h20, a, d);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    q.push_back(e);
    drv(6'h10, a, 32'h0);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Read results land one cycle after the strobe; compare mid-cycle
  always @(posedge clk_i) rd_flag <= reg_re_i;
  always @(negedge clk_i) if (rd_flag) chk("reg_rdata_o", q.pop_front(), reg_rdata_o);

  // Hang guard, well above the expected run length
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      give_verdict;
    end
  end

  initial begin
    repeat (5) @(posedge clk_i);
    srst_i <= 1'b0;
    @(negedge clk_i);
    chk("vec_req_o", 1, vec_req_o);
    chk("vec_addr_o", 20'h0FFFC, vec_addr_o);
    chk("flags_o", 0, flags_o);
    @(posedge clk_i);
    // Program counter write refused until the vector arrives
    wr(`RFX_IDX_PC, 32'h00012345);
    vec_data_i <= 20'h0C000;
    drv(6'h01, 5'h00, 32'h0);
    vec_data_i <= 20'h0ABCD;
    drv(6'h01, 5'h00, 32'h0);
    rd(`RFX_IDX_PC, 32'h0000C000);
    // Widths of the single registers, table base through static base
    for (i = 7; i < 12; i++) begin
      wr(i[4:0], 32'hFFFFFFFF);
      rd(i[4:0], (i < 9) ? 32'h000FFFFF : 32'h0000FFFF);
    end
    // Fill both banks with random data, then read back each entry, the three pair views and the D0 high and D1 low bytes
    for (b = 0; b < 2; b++) begin
      wr(`RFX_IDX_FLG, {27'h0, b[0], 4'h0});
      for (i = 0; i < 7; i++) begin
        bv[b][i] = 16'($random(seed));
        wr(i[4:0], {16'h0, bv[b][i]});
      end
    end
    for (b = 0; b < 2; b++) begin
      wr(`RFX_IDX_FLG, {27'h0, b[0], 4'h0});
      for (i = 0; i < 7; i++) rd(i[4:0], {16'h0, bv[b][i]});
      rd(`RFX_IDX_D0_HI, {24'h0, bv[b][0][15:8]});
      rd(`RFX_IDX_D1_LO, {24'h0, bv[b][1][7:0]});
      rd(`RFX_IDX_PAIR_LO, {bv[b][2], bv[b][0]});
      rd(`RFX_IDX_PAIR_HI, {bv[b][3], bv[b][1]});
      rd(`RFX_IDX_ADDR_PAIR, {bv[b][5], bv[b][4]});
    end
    wr(`RFX_IDX_D0_LO, 32'h000000A5);
    rd(`RFX_IDX_DATA0, {16'h0, bv[1][0][15:8], 8'hA5});
    wr(`RFX_IDX_D0_HI, 32'h000000C3);
    wr(`RFX_IDX_D1_HI, 32'h0000005A);
    rd(`RFX_IDX_D0_LO, 32'h000000A5);
    rd(`RFX_IDX_DATA0, 32'h0000C3A5);
    rd(`RFX_IDX_D1_HI, 32'h0000005A);
    rd(`RFX_IDX_DATA1, {16'h0, 8'h5A, bv[1][1][7:0]});
    wr(`RFX_IDX_PAIR_HI, 32'h12345678);
    rd(`RFX_IDX_DATA3, 32'h00001234);
    rd(`RFX_IDX_DATA1, 32'h00005678);
    wr(5'h1F, 32'hFFFFFFFF);
    rd(5'h1F, 32'h0);
    // ALU updates over all sizes, with zero at byte but not word boundary
    ef = 16'h0010;
    for (i = 0; i < 12; i++) begin
      r  = (i % 4 == 0) ? 32'h0 : (i % 4 == 1) ? 32'hFFFFFF00 : $random(seed);
      m  = (i < 3 || i == 11) ? 4'hF : 4'($random(seed));
      sz = (i == 11) ? 2'h3 : 2'(i % 3);
      alu_mask_i <= m;
      alu_size_i <= sz;
      alu_res_i  <= r;
      alu_c_i    <= r[3];
      alu_o_i    <= r[9];
      drv(6'h08, 5'h00, 32'h0);
      if (m[0]) ef[0] = r[3];
      if (m[1]) ef[2] = (sz == 0) ? r[7:0] == 0 : (sz == 1) ? r[15:0] == 0 : r == 0;
      if (m[2]) ef[3] = (sz == 0) ? r[7] : (sz == 1) ? r[15] : r[31];
      if (m[3]) ef[5] = r[9];
      rd(`RFX_IDX_FLG, {16'h0, ef});
    end
    // Priority gate, stack switch and acknowledge; debug flag kept 0
    wr(`RFX_IDX_USP, 32'h1111);
    wr(`RFX_IDX_ISP, 32'h2222);
    wr(`RFX_IDX_ACT_SP, 32'h00003333);
    rd(`RFX_IDX_ISP, 32'h00003333);
    wr(`RFX_IDX_FLG, 32'h000020C0);
    rd(`RFX_IDX_ACT_SP, 32'h00001111);
    irq_req_i <= 1'b1;
    for (i = 0; i < 8; i++) begin
      irq_lvl_i <= i[2:0];
      drv(6'h00, 5'h00, 32'h0);
      @(negedge clk_i);
      chk("irq_take_o", i > 2, irq_take_o);
      @(posedge clk_i);
    end
    chk("sp_o", 32'h1111, sp_o);
    drv(6'h04, 5'h00, 32'h0);
    hw_ack_i <= 1'b0;
    @(negedge clk_i);
    chk("flags_o", 32'h2000, flags_o);
    chk("sp_o", 32'h3333, sp_o);
    chk("vector_table_base_o", 32'h000FFFFF, vector_table_base_o);
    chk("pc_o", 32'h000FFFFF, pc_o);
    chk("irq_take_o", 0, irq_take_o);
    @(posedge clk_i);
    for (i = 32; i > 30; i--) begin
      wr(`RFX_IDX_FLG, 32'h000020C0);
      swi_num_i <= i[5:0];
      drv(6'h02, 5'h00, 32'h0);
      swi_exec_i <= 1'b0;
      @(negedge clk_i);
      chk("flags_o", (i == 32) ? 32'h2080 : 32'h2000, flags_o);
      @(posedge clk_i);
    end
    // Second reset in mid-run
    srst_i <= 1'b1;
    drv(6'h00, 5'h00, 32'h0);
    srst_i <= 1'b0;
    @(negedge clk_i);
    chk("flags_o", 0, flags_o);
    chk("vec_req_o", 1, vec_req_o);
    @(posedge clk_i);
    rd(`RFX_IDX_DATA0, 32'h0);
    drv(6'h00, 5'h00, 32'h0);
    drv(6'h00, 5'h00, 32'h0);
    give_verdict;
  end
endmodule // testbench
